//--- load_sync_unit.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - sync halts fetch until pipeline drains
// - later instructions see all earlier results
// - sync stays local, no external traffic
// - offset address is base-or-zero plus displacement
// - indexed address is base-or-zero plus index
// - byte load zero fills upper bits
// - update forms write address to base
// - double float load passes eight bytes
// - single float load converts to double
// - signed half load sign extends
// - swapped half load reverses bytes
// - swapped load adds no latency
module load_sync_unit
  import load_sync_pkg::*;
(
  // clock and reset
  input  wire logic               i_clock,
  input  wire logic               i_rst_n,
  // issued operation
  input  wire logic               i_valid,
  output logic                    o_ready,
  input  wire logic [3:0]         i_op,
  input  wire logic               i_indexed,
  input  wire logic               i_update,
  input  wire logic [REG_A_W-1:0] i_base_sel,
  input  wire logic [REG_A_W-1:0] i_dest_sel,
  input  wire logic [GPR_W-1:0]   i_base_gpr,
  input  wire logic [GPR_W-1:0]   i_index_gpr,
  input  wire logic [DISP_W-1:0]  i_disp,
  // pipeline occupancy for sync
  input  wire logic               i_inflight_busy,
  output logic                    o_fetch_halt,
  // memory read port
  output logic                    o_mem_req,
  output logic      [GPR_W-1:0]   o_mem_addr,
  output logic      [3:0]         o_mem_size,
  input  wire logic               i_mem_ack,
  input  wire logic [MEM_W-1:0]   i_mem_data,
  // write back
  output logic                    o_gpr_we,
  output logic      [REG_A_W-1:0] o_gpr_sel,
  output logic      [GPR_W-1:0]   o_gpr_data,
  output logic                    o_fpr_we,
  output logic      [REG_A_W-1:0] o_fpr_sel,
  output logic      [FPR_W-1:0]   o_fpr_data,
  output logic                    o_base_we,
  output logic      [REG_A_W-1:0] o_base_sel,
  output logic      [GPR_W-1:0]   o_base_data,
  output logic                    o_invalid_form
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_SYNC = 2'b10
  } state_e;

  function automatic logic [3:0] op_size(input logic [3:0] op);
    case (load_op_e'(op))
      OP_BYTE_ZERO:    op_size = SIZE_BYTE;
      OP_HALF_ZERO,
      OP_HALF_SIGNED,
      OP_HALF_SWAPPED: op_size = SIZE_HALF;
      OP_FLOAT_DOUBLE: op_size = SIZE_DOUBLE;
      default:         op_size = SIZE_WORD;
    endcase
  endfunction : op_size

  function automatic logic is_float(input logic [3:0] op);
    is_float = (load_op_e'(op) == OP_FLOAT_SINGLE) ||
               (load_op_e'(op) == OP_FLOAT_DOUBLE);
  endfunction : is_float

  state_e             state_r,     state_nxt;
  logic [3:0]         op_r,        op_nxt;
  logic               upd_r,       upd_nxt;
  logic [REG_A_W-1:0] base_sel_r,  base_sel_nxt;
  logic [REG_A_W-1:0] dest_sel_r,  dest_sel_nxt;
  logic [GPR_W-1:0]   addr_r,      addr_nxt;
  logic               gpr_we_r,    gpr_we_nxt;
  logic               fpr_we_r,    fpr_we_nxt;
  logic               base_we_r,   base_we_nxt;
  logic               invalid_r,   invalid_nxt;
  logic [GPR_W-1:0]   gpr_data_r,  gpr_data_nxt;
  logic [FPR_W-1:0]   fpr_data_r,  fpr_data_nxt;

  logic [GPR_W-1:0]   base_val;
  logic [GPR_W-1:0]   offset_val;
  logic [GPR_W-1:0]   ea;
  logic               bad_form;
  logic [GPR_W-1:0]   fmt_gpr;
  logic [FPR_W-1:0]   fmt_fpr;

  load_format u_format (
    .i_op        (op_r),
    .i_mem_data  (i_mem_data),
    .o_gpr_value (fmt_gpr),
    .o_fpr_value (fmt_fpr)
  );

  // zero base field reads as zero, except in update forms
  assign base_val = (i_base_sel == REG_ZERO && !i_update) ?
                    GPR_RESET : i_base_gpr;
  assign offset_val = i_indexed ? i_index_gpr :
                      {{(GPR_W-DISP_W){i_disp[DISP_W-1]}}, i_disp};
  assign ea = base_val + offset_val;

  // flag forms that software must not issue
  assign bad_form = i_update && ((i_base_sel == REG_ZERO) ||
                    (!is_float(i_op) && i_base_sel == i_dest_sel));

  always_comb begin
    state_nxt    = state_r;
    op_nxt       = op_r;
    upd_nxt      = upd_r;
    base_sel_nxt = base_sel_r;
    dest_sel_nxt = dest_sel_r;
    addr_nxt     = addr_r;
    gpr_we_nxt   = 1'b0;
    fpr_we_nxt   = 1'b0;
    base_we_nxt  = 1'b0;
    invalid_nxt  = 1'b0;
    gpr_data_nxt = gpr_data_r;
    fpr_data_nxt = fpr_data_r;
    case (state_r)
      ST_IDLE: begin
        if (i_valid) begin
          if (load_op_e'(i_op) == OP_SYNC) begin
            state_nxt = ST_SYNC;
          end else if (!(load_op_e'(i_op) inside
                       {[OP_BYTE_ZERO:OP_FLOAT_DOUBLE]})) begin
            // unused codes are dropped without a flag
            state_nxt = ST_IDLE;
          end else if (bad_form) begin
            invalid_nxt = 1'b1;
          end else begin
            state_nxt    = ST_READ;
            op_nxt       = i_op;
            upd_nxt      = i_update;
            base_sel_nxt = i_base_sel;
            dest_sel_nxt = i_dest_sel;
            addr_nxt     = ea;
          end
        end
      end
      ST_READ: begin
        // all load kinds, swapped included, finish on the ack
        if (i_mem_ack) begin
          state_nxt = ST_IDLE;
          if (is_float(op_r)) begin
            fpr_we_nxt   = 1'b1;
            fpr_data_nxt = fmt_fpr;
          end else begin
            gpr_we_nxt   = 1'b1;
            gpr_data_nxt = fmt_gpr;
          end
          base_we_nxt = upd_r;
        end
      end
      ST_SYNC: begin
        // wait for pipeline to drain; no bus traffic issued
        if (!i_inflight_busy) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_r    <= ST_IDLE;
      op_r       <= OP_NONE;
      upd_r      <= 1'b0;
      base_sel_r <= REG_ZERO;
      dest_sel_r <= REG_ZERO;
      addr_r     <= GPR_RESET;
      gpr_we_r   <= 1'b0;
      fpr_we_r   <= 1'b0;
      base_we_r  <= 1'b0;
      invalid_r  <= 1'b0;
      gpr_data_r <= GPR_RESET;
      fpr_data_r <= FPR_RESET;
    end else begin
      state_r    <= state_nxt;
      op_r       <= op_nxt;
      upd_r      <= upd_nxt;
      base_sel_r <= base_sel_nxt;
      dest_sel_r <= dest_sel_nxt;
      addr_r     <= addr_nxt;
      gpr_we_r   <= gpr_we_nxt;
      fpr_we_r   <= fpr_we_nxt;
      base_we_r  <= base_we_nxt;
      invalid_r  <= invalid_nxt;
      gpr_data_r <= gpr_data_nxt;
      fpr_data_r <= fpr_data_nxt;
    end
  end

  assign o_ready        = (state_r == ST_IDLE);
  assign o_fetch_halt   = (state_r == ST_SYNC);
  assign o_mem_req      = (state_r == ST_READ);
  assign o_mem_addr     = addr_r;
  assign o_mem_size     = op_size(op_r);
  assign o_gpr_we       = gpr_we_r;
  assign o_gpr_sel      = dest_sel_r;
  assign o_gpr_data     = gpr_data_r;
  assign o_fpr_we       = fpr_we_r;
  assign o_fpr_sel      = dest_sel_r;
  assign o_fpr_data     = fpr_data_r;
  assign o_base_we      = base_we_r;
  assign o_base_sel     = base_sel_r;
  assign o_base_data    = addr_r;
  assign o_invalid_form = invalid_r;

endmodule : load_sync_unit
`default_nettype wire

//--- load_sync_pkg.sv
package load_sync_pkg;

  // load operation kinds
  typedef enum logic [3:0] {
    OP_NONE         = 4'h0,
    OP_BYTE_ZERO    = 4'h1,
    OP_HALF_ZERO    = 4'h2,
    OP_HALF_SIGNED  = 4'h3,
    OP_HALF_SWAPPED = 4'h4,
    OP_WORD         = 4'h5,
    OP_FLOAT_SINGLE = 4'h6,
    OP_FLOAT_DOUBLE = 4'h7,
    OP_SYNC         = 4'h8
  } load_op_e;

  localparam int unsigned GPR_W   = 32;
  localparam int unsigned FPR_W   = 64;
  localparam int unsigned DISP_W  = 16;
  localparam int unsigned REG_A_W = 5;
  localparam int unsigned MEM_W   = 64;

  // byte counts per access size
  localparam logic [3:0] SIZE_BYTE   = 4'h1;
  localparam logic [3:0] SIZE_HALF   = 4'h2;
  localparam logic [3:0] SIZE_WORD   = 4'h4;
  localparam logic [3:0] SIZE_DOUBLE = 4'h8;

  localparam logic [REG_A_W-1:0] REG_ZERO = 5'h00;
  localparam logic [GPR_W-1:0]   GPR_RESET = 32'h0000_0000;
  localparam logic [FPR_W-1:0]   FPR_RESET = 64'h0000_0000_0000_0000;

  // single to double conversion constants
  localparam logic [10:0] DBL_EXP_MAX  = 11'h7ff;
  localparam logic [10:0] DBL_EXP_BIAS = 11'h380;

endpackage : load_sync_pkg

//--- load_format.sv
`timescale 1ns/1ns
`default_nettype none
module load_format
  import load_sync_pkg::*;
(
  // operation and raw memory data, big-endian, left aligned
  input  wire logic [3:0]       i_op,
  input  wire logic [MEM_W-1:0] i_mem_data,
  // formatted results
  output logic      [GPR_W-1:0] o_gpr_value,
  output logic      [FPR_W-1:0] o_fpr_value
);

  function automatic logic [FPR_W-1:0] single_to_double(
    input logic [31:0] s
  );
    logic [10:0] e;
    logic [51:0] f;
    logic [22:0] m;
    int          lead;
    e    = 11'h000;
    f    = 52'h0;
    m    = s[22:0];
    lead = 0;
    if (s[30:23] == 8'hff) begin
      e = DBL_EXP_MAX;
      f = {m, 29'h0};
    end else if (s[30:23] != 8'h00) begin
      e = {3'h0, s[30:23]} + DBL_EXP_BIAS;
      f = {m, 29'h0};
    end else if (m != 23'h0) begin
      // denormal single normalizes into double range
      for (int i = 0; i < 23; i++) begin
        if (m[i]) begin
          lead = 22 - i;
        end
      end
      m = m << (lead + 1);
      e = DBL_EXP_BIAS + 11'h001 - 11'(lead + 1);
      f = {m, 29'h0};
    end
    return {s[31], e, f};
  endfunction : single_to_double

  logic [7:0]  b0;
  logic [7:0]  b1;
  logic [15:0] half;
  logic [31:0] word;

  // lowest address in the top byte
  assign b0   = i_mem_data[63:56];
  assign b1   = i_mem_data[55:48];
  assign half = {b0, b1};
  assign word = i_mem_data[63:32];

  always_comb begin
    o_gpr_value = GPR_RESET;
    o_fpr_value = FPR_RESET;
    case (load_op_e'(i_op))
      OP_BYTE_ZERO:    o_gpr_value = {24'h0, b0};
      OP_HALF_ZERO:    o_gpr_value = {16'h0, half};
      OP_HALF_SIGNED:  o_gpr_value = {{16{half[15]}}, half};
      OP_HALF_SWAPPED: o_gpr_value = {16'h0, b1, b0};
      OP_WORD:         o_gpr_value = word;
      OP_FLOAT_SINGLE: o_fpr_value = single_to_double(word);
      OP_FLOAT_DOUBLE: o_fpr_value = i_mem_data;
      default:         o_gpr_value = GPR_RESET;
    endcase
  end

endmodule : load_format
`default_nettype wire

//--- load_sync_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module load_sync_assertions
  import load_sync_pkg::*;
(
  // watched ports
  input wire logic               i_clock,
  input wire logic               i_rst_n,
  input wire logic               i_valid,
  input wire logic               o_ready,
  input wire logic [3:0]         i_op,
  input wire logic               i_indexed,
  input wire logic               i_update,
  input wire logic [REG_A_W-1:0] i_base_sel,
  input wire logic [GPR_W-1:0]   i_base_gpr,
  input wire logic [GPR_W-1:0]   i_index_gpr,
  input wire logic [DISP_W-1:0]  i_disp,
  input wire logic               i_inflight_busy,
  input wire logic               o_fetch_halt,
  input wire logic               o_mem_req,
  input wire logic [GPR_W-1:0]   o_mem_addr,
  input wire logic               i_mem_ack,
  input wire logic               o_gpr_we,
  input wire logic [GPR_W-1:0]   o_gpr_data,
  input wire logic               o_fpr_we,
  input wire logic               o_base_we,
  input wire logic [GPR_W-1:0]   o_base_data
);
  logic [3:0]       op_r, op_nxt;
  logic [GPR_W-1:0] ea_r, ea_nxt;
  // expected address and op kept from the accepted issue
  always_comb begin
    op_nxt = op_r;
    ea_nxt = ea_r;
    if (i_valid && o_ready) begin
      op_nxt = i_op;
      ea_nxt = (i_base_sel == REG_ZERO ? GPR_RESET : i_base_gpr)
        + (i_indexed ? i_index_gpr : {{16{i_disp[15]}}, i_disp});
    end
  end
  always_ff @(posedge i_clock) begin
    op_r <= op_nxt;
    ea_r <= ea_nxt;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_halt_hold: assert property (
    o_fetch_halt && i_inflight_busy |=> o_fetch_halt)
    else $error("fetch halt dropped while busy");
  a_halt_release: assert property (
    o_fetch_halt && !i_inflight_busy |=> !o_fetch_halt && o_ready)
    else $error("fetch halt kept after drain");
  a_sync_local: assert property (
    o_fetch_halt |-> !o_mem_req)
    else $error("memory traffic during sync");
  a_ea_value: assert property (
    i_valid && o_ready && !i_update && i_op inside {[4'h1:4'h7]}
    |=> o_mem_req && o_mem_addr == ea_r)
    else $error("wrong effective address");
  a_byte_fill: assert property (
    o_gpr_we && op_r == OP_BYTE_ZERO |-> o_gpr_data[31:8] == 24'h0)
    else $error("byte load not zero filled");
  a_half_sign: assert property (
    o_gpr_we && op_r == OP_HALF_SIGNED
    |-> o_gpr_data[31:16] == {16{o_gpr_data[15]}})
    else $error("half load not sign extended");
  a_swap_fill: assert property (
    o_gpr_we && op_r == OP_HALF_SWAPPED |-> o_gpr_data[31:16] == 16'h0)
    else $error("swapped half not zero filled");
  a_base_upd: assert property (
    o_base_we |-> o_base_data == ea_r && (o_gpr_we || o_fpr_we))
    else $error("base write back wrong");
  a_ack_wb: assert property (
    o_mem_req && i_mem_ack |=> (o_gpr_we || o_fpr_we) && o_ready)
    else $error("write back late after answer");
  c_sync: cover property (o_fetch_halt ##1 !o_fetch_halt);
  c_upd: cover property (o_base_we);
  c_swap: cover property (o_gpr_we && op_r == OP_HALF_SWAPPED);
endmodule : load_sync_assertions
`default_nettype wire

//--- data_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module data_mem_model (
  // clock, reset and answer delay
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_lat,
  // read port
  input  wire logic        i_req,
  input  wire logic [31:0] i_addr,
  output logic             o_ack,
  output logic [63:0]      o_data
);
  logic [3:0] cnt;
  // data scrambles every cycle outside an answer
  always_ff @(posedge i_clock) begin
    o_ack <= 1'b0;
    o_data <= ~o_data;
    cnt <= 4'h0;
    if (i_rst_n && i_req && !o_ack) begin
      cnt <= cnt + 4'h1;
      if (cnt == i_lat) begin
        o_ack <= 1'b1;
        o_data <= {i_addr, ~i_addr};
      end
    end
    if (!i_rst_n) o_data <= 64'h0;
  end
endmodule : data_mem_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import load_sync_pkg::*;
  logic        i_clock = 1'b0, i_rst_n = 1'b0, i_valid = 1'b0;
  logic        i_indexed = 1'b0, i_update = 1'b0, i_inflight_busy = 1'b0;
  logic [3:0]  i_op = 4'h0, mem_lat = 4'h0, o_mem_size;
  logic [4:0]  i_base_sel = 5'h00, i_dest_sel = 5'h00;
  logic [4:0]  o_gpr_sel, o_fpr_sel, o_base_sel;
  logic [31:0] i_base_gpr = 32'h0, i_index_gpr = 32'h0;
  logic [31:0] o_mem_addr, o_gpr_data, o_base_data;
  logic [15:0] i_disp = 16'h0;
  logic [63:0] i_mem_data, o_fpr_data;
  logic        o_ready, o_fetch_halt, o_mem_req, i_mem_ack, o_invalid_form;
  logic        o_gpr_we, o_fpr_we, o_base_we;
  int          n_mismatch = 0, check_count = 0;
  always #4 i_clock = ~i_clock;
  load_sync_unit dut_u (.i_clock, .i_rst_n, .i_valid, .o_ready, .i_op,
    .i_indexed, .i_update, .i_base_sel, .i_dest_sel, .i_base_gpr,
    .i_index_gpr, .i_disp, .i_inflight_busy, .o_fetch_halt, .o_mem_req,
    .o_mem_addr, .o_mem_size, .i_mem_ack, .i_mem_data, .o_gpr_we,
    .o_gpr_sel, .o_gpr_data, .o_fpr_we, .o_fpr_sel, .o_fpr_data,
    .o_base_we, .o_base_sel, .o_base_data, .o_invalid_form);
  data_mem_model mem_u (.i_clock, .i_rst_n, .i_lat(mem_lat),
    .i_req(o_mem_req), .i_addr(o_mem_addr), .o_ack(i_mem_ack),
    .o_data(i_mem_data));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic issue(input logic [3:0] op, input logic [4:0] bs, ds,
      input logic [31:0] b, x, input logic [15:0] d, input logic ix, up);
    @(posedge i_clock);
    i_valid <= 1'b1;
    i_op <= op;
    i_base_sel <= bs;
    i_dest_sel <= ds;
    i_base_gpr <= b;
    i_index_gpr <= x;
    i_disp <= d;
    i_indexed <= ix;
    i_update <= up;
    @(posedge i_clock);
    i_valid <= 1'b0;
  endtask : issue
  // waits for the write back or refusal pulse
  // exp_n counts falling edges from the issue edge to the pulse
  task automatic finish_op(input int exp_n);
    int n;
    n = 0;
    do begin
      @(negedge i_clock);
      n++;
    end while (!(o_gpr_we | o_fpr_we | o_invalid_form) && n < 40);
    chk(n, exp_n);
  endtask : finish_op
  task automatic t_int_offset;
    logic [31:0] ea, e;
    logic [3:0]  sz;
    for (int k = 1; k <= 5; k++) begin
      ea = (k == 5 ? 32'h0 : 32'h8070_9f10 + k) + 32'hffff_fff0;
      issue(k, (k == 5) ? 5'h0 : k, 5'h9, 32'h8070_9f10 + k, 32'hffff_fff0,
        16'hfff0, k == 4, 1'b0);
      finish_op(3);
      sz = (k == 1) ? SIZE_BYTE : (k == 5) ? SIZE_WORD : SIZE_HALF;
      chk(o_mem_size, sz);
      case (k)
        1: e = {24'h0, ea[31:24]};
        2: e = {16'h0, ea[31:16]};
        3: e = {{16{ea[31]}}, ea[31:16]};
        4: e = {16'h0, ea[23:16], ea[31:24]};
        default: e = ea;
      endcase
      chk(o_gpr_data, e);
      chk(o_gpr_sel, 5'h9);
    end
  endtask : t_int_offset
  task automatic t_update_slow;
    mem_lat = 4'h5;
    issue(OP_HALF_SIGNED, 5'h3, 5'h4, 32'h1000, 32'h0234, 16'h0, 1, 1);
    finish_op(8);
    chk(o_gpr_data, 32'h0);
    chk({o_base_we, o_base_sel, o_base_data}, {1'b1, 5'h3, 32'h1234});
    issue(OP_FLOAT_DOUBLE, 5'h2, 5'h2, 32'h1000_0000, 0, 16'h8, 0, 1);
    finish_op(8);
    chk(o_mem_size, SIZE_DOUBLE);
    chk(o_fpr_data, {32'h1000_0008, ~32'h1000_0008});
    chk({o_base_we, o_base_data}, {1'b1, 32'h1000_0008});
    mem_lat = 4'h0;
  endtask : t_update_slow
  task automatic t_float_single;
    issue(OP_FLOAT_SINGLE, 5'h0, 5'h5, 32'hdead_0000, 32'h3f80_0000, 0, 1, 0);
    finish_op(3);
    chk(o_mem_size, SIZE_WORD);
    chk({o_fpr_we, o_fpr_sel}, {1'b1, 5'h5});
    chk(o_fpr_data, 64'h3ff0_0000_0000_0000);
  endtask : t_float_single
  task automatic t_invalid;
    issue(OP_BYTE_ZERO, 5'h0, 5'h1, 32'h40, 0, 16'h4, 0, 1);
    finish_op(1);
    chk({o_invalid_form, o_mem_req, o_gpr_we}, 3'b100);
    issue(OP_WORD, 5'h7, 5'h7, 32'h40, 32'h4, 0, 1, 1);
    finish_op(1);
    chk({o_invalid_form, o_mem_req, o_base_we}, 3'b100);
    // unused code with a bad base field: neither flagged nor read
    issue(4'hf, 5'h0, 5'h1, 32'h40, 0, 16'h4, 0, 1);
    @(negedge i_clock);
    chk({o_invalid_form, o_mem_req, o_ready}, 3'b001);
  endtask : t_invalid
  task automatic t_sync;
    @(posedge i_clock);
    i_inflight_busy <= 1'b1;
    issue(OP_SYNC, 0, 0, 0, 0, 0, 0, 0);
    repeat (4) @(negedge i_clock);
    chk({o_fetch_halt, o_ready, o_mem_req}, 3'b100);
    @(posedge i_clock);
    i_inflight_busy <= 1'b0;
    @(posedge i_clock);
    @(negedge i_clock);
    chk({o_fetch_halt, o_ready}, 2'b01);
  endtask : t_sync
  initial begin
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_int_offset();
    t_update_slow();
    t_float_single();
    t_invalid();
    t_sync();
    t_float_single();
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge i_clock);
    n_mismatch++;
    wrap_up();
  end
endmodule : testbench
bind load_sync_unit load_sync_assertions chk_u (.i_clock, .i_rst_n,
  .i_valid, .o_ready, .i_op, .i_indexed, .i_update, .i_base_sel,
  .i_base_gpr, .i_index_gpr, .i_disp, .i_inflight_busy, .o_fetch_halt,
  .o_mem_req, .o_mem_addr, .i_mem_ack, .o_gpr_we, .o_gpr_data, .o_fpr_we,
  .o_base_we, .o_base_data);
`default_nettype wire
